/* File: verilog/i2s_ctrl_defs.vh */
// Constants for the audio serial port FIFO and DMA control block.
// Assumes byte addressing on a 32-bit APB bus, one word per register.
`ifndef I2S_CTRL_DEFS_VH
`define I2S_CTRL_DEFS_VH

`define OFS_INT_STATUS 12'h038
`define OFS_INT_MASK 12'h03C
`define OFS_RX_OVR 12'h040
`define OFS_TX_OVR 12'h044
`define OFS_RX_TRIG 12'h048
`define OFS_TX_TRIG 12'h04C
`define OFS_RX_FLUSH 12'h050
`define OFS_TX_FLUSH 12'h054
`define OFS_RX_DMA 12'h1C0
`define OFS_RX_DMA_RST 12'h1C4
`define OFS_TX_DMA 12'h1C8
`define OFS_TX_DMA_RST 12'h1CC
`define OFS_PARAM_RX 12'h1F0
`define OFS_PARAM_TX 12'h1F4

`define ST_RX_AVAIL 0
`define ST_RX_OVR 1
`define ST_TX_EMPTY 4
`define ST_TX_OVR 5
`define ST_W 6
`define ST_USED 6'h33
`define MASK_RESET 6'h33

`define TRIG_W 4
`define TRIG_RESET 4'h3
`define LEVEL_W 5

// Flush and pointer-reset strobes and the overrun flags sit in bit 0
`define CTRL_BIT 0

`define NCH 4
`define CH_W 2

// Word size codes: 0=12, 1=16, 2=20, 3=24, 4=32 bits
`define WS_W 3
`define RX_WS0 3'h0
`define RX_WS1 3'h0
`define RX_WS2 3'h0
`define RX_WS3 3'h0
`define TX_WS0 3'h0
`define TX_WS1 3'h0
`define TX_WS2 3'h0
`define TX_WS3 3'h0
`define RX_WS0_LSB 0
`define RX_WS1_LSB 3
`define RX_WS2_LSB 7
`define RX_WS3_LSB 10
`define TX_WS0_LSB 16
`define TX_WS1_LSB 19
`define TX_WS2_LSB 22
`define TX_WS3_LSB 25

`endif

/* File: verilog/i2s_fifo_dma_control.v */
// Register-side control of a four-channel audio serial port: interrupt
// status/mask, overrun read-to-clear, FIFO trigger levels, FIFO flush
// strobes, block DMA ports and word-size parameter registers.
// Assumes an APB master, and FIFOs outside that report fill levels,
// overrun pulses and per-channel data at the selected channel/side.
//
// Functional notes
// [R1] Reading the receive overrun register returns and clears RX overrun.
// [R2] Reading the transmit overrun register returns and clears TX overrun.
// [R3] RX data-available sets when RX fill reaches 4-bit trigger, reset 3.
// [R4] TX empty-threshold sets when TX fill falls to 4-bit trigger, reset 3.
// [R5] Writing 1 to RX flush bit pulses a flush of the RX FIFO.
// [R6] Software disables the receive channel before flushing it.
// [R7] Writing 1 to TX flush bit pulses a flush of the TX FIFO.
// [R8] Software disables the transmit channel before flushing it.
// [R9] RX DMA port reads cycle enabled channels lowest first, left then right.
// [R10] TX DMA port writes cycle enabled channels lowest first, left then right.
// [R11] RX DMA reset bit returns the RX sequence to lowest enabled channel.
// [R12] TX DMA reset bit returns the TX sequence to lowest enabled channel.
// [R13] RX parameter register reports 3-bit word size per receive channel.
// [R14] TX parameter register reports 3-bit word sizes, ch3 27:25, ch2 24:22.
// [R15] RX data-available mask is mask bit 0, resets to 1 (masked).
// [R16] Status bits: TX overrun 5, TX empty 4, RX overrun 1, RX avail 0.
// [R17] Interrupt output is high while a set status bit is unmasked.
`timescale 1ns/1ps
`default_nettype none
`include "i2s_ctrl_defs.vh"

module i2s_fifo_dma_control (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [`LEVEL_W-1:0] rx_fifo_level,
  input wire [`LEVEL_W-1:0] tx_fifo_level,
  input wire rx_overrun_evt,
  input wire tx_overrun_evt,
  input wire [`NCH-1:0] rx_ch_enable,
  input wire [`NCH-1:0] tx_ch_enable,
  input wire [31:0] rx_dma_rdata,
  output reg [`CH_W-1:0] rx_dma_ch,
  output reg rx_dma_right,
  output reg rx_dma_pop,
  output reg [`CH_W-1:0] tx_dma_ch,
  output reg tx_dma_right,
  output reg tx_dma_push,
  output reg [31:0] tx_dma_wdata,
  output reg rx_fifo_flush,
  output reg tx_fifo_flush,
  output wire irq
);

  reg [`ST_W-1:0] status_q;
  reg [`ST_W-1:0] status_d;
  reg [`ST_W-1:0] mask_q;
  reg [`TRIG_W-1:0] rx_trig_q;
  reg [`TRIG_W-1:0] tx_trig_q;
  reg [31:0] rdata_d;
  reg known;

  wire setup_ph;
  wire access_ph;
  wire wr_done;
  wire rd_done;
  wire rx_avail_cond;
  wire tx_empty_cond;
  wire [31:0] param_rx;
  wire [31:0] param_tx;
  wire clr_rx_ovr;
  wire clr_tx_ovr;
  wire rx_dma_rd;
  wire tx_dma_wr;
  wire rx_dma_rst;
  wire tx_dma_rst;

  // Next enabled channel above cur, wrapping; cur kept if none enabled
  function [`CH_W-1:0] next_ch;
    input [`CH_W-1:0] cur;
    input [`NCH-1:0] en;
    integer i;
    reg found;
    reg [`CH_W-1:0] idx;
    begin
      next_ch = cur;
      found = 1'b0;
      for (i = 1; i <= `NCH; i = i + 1)
      begin
        idx = cur + i[`CH_W-1:0];
        if (!found && en[idx])
        begin
          next_ch = idx;
          found = 1'b1;
        end
      end
    end
  endfunction

  // Lowest enabled channel, channel 0 if none enabled
  function [`CH_W-1:0] low_ch;
    input [`NCH-1:0] en;
    integer i;
    reg found;
    begin
      low_ch = {`CH_W{1'b0}};
      found = 1'b0;
      for (i = 0; i < `NCH; i = i + 1)
      begin
        if (!found && en[i])
        begin
          low_ch = i[`CH_W-1:0];
          found = 1'b1;
        end
      end
    end
  endfunction

  // Address match used by both bus phases
  function hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      hit = (a[11:2] == ofs[11:2]);
    end
  endfunction

  // Every register this block answers; anything else is a slave error
  function mapped;
    input [11:0] a;
    begin
      mapped = hit(a, `OFS_INT_STATUS) | hit(a, `OFS_INT_MASK)
               | hit(a, `OFS_RX_OVR) | hit(a, `OFS_TX_OVR)
               | hit(a, `OFS_RX_TRIG) | hit(a, `OFS_TX_TRIG)
               | hit(a, `OFS_RX_FLUSH) | hit(a, `OFS_TX_FLUSH)
               | hit(a, `OFS_RX_DMA) | hit(a, `OFS_RX_DMA_RST)
               | hit(a, `OFS_TX_DMA) | hit(a, `OFS_TX_DMA_RST)
               | hit(a, `OFS_PARAM_RX) | hit(a, `OFS_PARAM_TX);
    end
  endfunction

  // One word-size code widened and placed at its field of a parameter word
  function [31:0] ws_field;
    input [`WS_W-1:0] code;
    input integer lsb;
    begin
      ws_field = {{(32-`WS_W){1'b0}}, code} << lsb;
    end
  endfunction

  // Zero-wait-state slave: read data is captured in the setup cycle,
  // so side effects happen only once, at the completing access edge.
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign pready = 1'b1;
  assign wr_done = access_ph & pwrite;
  assign rd_done = access_ph & ~pwrite;

  // A read clears only an overrun it actually returned: an event that
  // lands after the setup capture stays set for the next read.
  assign clr_rx_ovr = rd_done & hit(paddr, `OFS_RX_OVR) & prdata[`CTRL_BIT];
  assign clr_tx_ovr = rd_done & hit(paddr, `OFS_TX_OVR) & prdata[`CTRL_BIT];

  // DMA port and pointer-reset decodes
  assign rx_dma_rd = rd_done & hit(paddr, `OFS_RX_DMA);
  assign tx_dma_wr = wr_done & hit(paddr, `OFS_TX_DMA);
  assign rx_dma_rst = wr_done & hit(paddr, `OFS_RX_DMA_RST)
                      & pwdata[`CTRL_BIT];
  assign tx_dma_rst = wr_done & hit(paddr, `OFS_TX_DMA_RST)
                      & pwdata[`CTRL_BIT];

  always @*
  begin
    known = mapped(paddr);
  end

  assign pslverr = access_ph & ~known;

  assign param_rx = ws_field(`RX_WS0, `RX_WS0_LSB) // [R13]
                    | ws_field(`RX_WS1, `RX_WS1_LSB)
                    | ws_field(`RX_WS2, `RX_WS2_LSB)
                    | ws_field(`RX_WS3, `RX_WS3_LSB);
  assign param_tx = ws_field(`TX_WS0, `TX_WS0_LSB) // [R14]
                    | ws_field(`TX_WS1, `TX_WS1_LSB)
                    | ws_field(`TX_WS2, `TX_WS2_LSB)
                    | ws_field(`TX_WS3, `TX_WS3_LSB);

  always @*
  begin
    rdata_d = 32'h0;
    if (hit(paddr, `OFS_INT_STATUS))
      rdata_d = {26'h0, status_q};
    else if (hit(paddr, `OFS_INT_MASK))
      rdata_d = {26'h0, mask_q};
    else if (hit(paddr, `OFS_RX_OVR))
      rdata_d = {31'h0, status_q[`ST_RX_OVR]}; // [R1]
    else if (hit(paddr, `OFS_TX_OVR))
      rdata_d = {31'h0, status_q[`ST_TX_OVR]}; // [R2]
    else if (hit(paddr, `OFS_RX_TRIG))
      rdata_d = {28'h0, rx_trig_q};
    else if (hit(paddr, `OFS_TX_TRIG))
      rdata_d = {28'h0, tx_trig_q};
    else if (hit(paddr, `OFS_RX_DMA))
      rdata_d = rx_dma_rdata; // [R9]
    else if (hit(paddr, `OFS_PARAM_RX))
      rdata_d = param_rx;
    else if (hit(paddr, `OFS_PARAM_TX))
      rdata_d = param_tx;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (setup_ph && !pwrite)
      prdata <= rdata_d;
  end

  // Level conditions keep re-setting their sticky bit while they hold
  assign rx_avail_cond = (rx_fifo_level >= {1'b0, rx_trig_q}); // [R3]
  assign tx_empty_cond = (tx_fifo_level <= {1'b0, tx_trig_q}); // [R4]

  always @*
  begin
    status_d = status_q;
    if (wr_done && hit(paddr, `OFS_INT_STATUS))
      status_d = status_d & ~pwdata[`ST_W-1:0];
    if (clr_rx_ovr)
      status_d[`ST_RX_OVR] = 1'b0; // [R1]
    if (clr_tx_ovr)
      status_d[`ST_TX_OVR] = 1'b0; // [R2]
    // Setting after clearing lets a same-cycle event win over the clear
    if (rx_avail_cond)
      status_d[`ST_RX_AVAIL] = 1'b1; // [R3] [R16]
    if (rx_overrun_evt)
      status_d[`ST_RX_OVR] = 1'b1; // [R16]
    if (tx_empty_cond)
      status_d[`ST_TX_EMPTY] = 1'b1; // [R4] [R16]
    if (tx_overrun_evt)
      status_d[`ST_TX_OVR] = 1'b1; // [R16]
    status_d = status_d & `ST_USED;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_q <= {`ST_W{1'b0}};
      mask_q <= `MASK_RESET; // [R15]
      rx_trig_q <= `TRIG_RESET; // [R3]
      tx_trig_q <= `TRIG_RESET; // [R4]
    end
    else
    begin
      status_q <= status_d;
      if (wr_done && hit(paddr, `OFS_INT_MASK))
        mask_q <= pwdata[`ST_W-1:0] & `ST_USED; // [R15]
      if (wr_done && hit(paddr, `OFS_RX_TRIG))
        rx_trig_q <= pwdata[`TRIG_W-1:0]; // [R3]
      if (wr_done && hit(paddr, `OFS_TX_TRIG))
        tx_trig_q <= pwdata[`TRIG_W-1:0]; // [R4]
    end
  end

  assign irq = |(status_q & ~mask_q); // [R17]

  // Flush strobes: one cycle; the channel is assumed already disabled
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_fifo_flush <= 1'b0;
      tx_fifo_flush <= 1'b0;
    end
    else
    begin
      rx_fifo_flush <= wr_done & hit(paddr, `OFS_RX_FLUSH)
                       & pwdata[`CTRL_BIT]; // [R5] [R6]
      tx_fifo_flush <= wr_done & hit(paddr, `OFS_TX_FLUSH)
                       & pwdata[`CTRL_BIT]; // [R7] [R8]
    end
  end

  // Receive DMA sequence: left then right of a channel, then next one
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_dma_ch <= {`CH_W{1'b0}};
      rx_dma_right <= 1'b0;
      rx_dma_pop <= 1'b0;
    end
    else
    begin
      rx_dma_pop <= rx_dma_rd;
      if (rx_dma_rst)
      begin
        rx_dma_ch <= low_ch(rx_ch_enable); // [R11]
        rx_dma_right <= 1'b0;
      end
      else if (rx_dma_rd)
      begin
        rx_dma_right <= ~rx_dma_right; // [R9]
        if (rx_dma_right)
          rx_dma_ch <= next_ch(rx_dma_ch, rx_ch_enable); // [R9]
      end
    end
  end

  // Transmit DMA sequence mirrors the receive one, driven by writes
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_dma_ch <= {`CH_W{1'b0}};
      tx_dma_right <= 1'b0;
      tx_dma_push <= 1'b0;
      tx_dma_wdata <= 32'h0;
    end
    else
    begin
      tx_dma_push <= tx_dma_wr;
      if (tx_dma_wr)
        tx_dma_wdata <= pwdata; // [R10]
      if (tx_dma_rst)
      begin
        tx_dma_ch <= low_ch(tx_ch_enable); // [R12]
        tx_dma_right <= 1'b0;
      end
      else if (tx_dma_wr)
      begin
        tx_dma_right <= ~tx_dma_right; // [R10]
        if (tx_dma_right)
          tx_dma_ch <= next_ch(tx_dma_ch, tx_ch_enable); // [R10]
      end
    end
  end

endmodule // i2s_fifo_dma_control

`default_nettype wire

/* File: tb/fifo_side_model.sv */
// Far-side FIFO model: answers with a word naming the selected
// channel and side, so any ordering fault shows in the read data.
`timescale 1ns/1ps
`default_nettype none
module fifo_side_model (
  input wire logic [1:0] rx_dma_ch,
  input wire logic rx_dma_right,
  output logic [31:0] rx_dma_rdata
);
  assign rx_dma_rdata = {28'hA0D0000, 1'b0, rx_dma_ch, rx_dma_right};
endmodule // fifo_side_model
`default_nettype wire

/* File: tb/i2s_ctrl_assertions.sv */
// Port-level checks of the FIFO/DMA control block.
// Assumes byte addresses from the shared offset header.
`timescale 1ns/1ps
`default_nettype none
`include "i2s_ctrl_defs.vh"
module i2s_ctrl_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic rx_dma_right,
  input wire logic rx_dma_pop,
  input wire logic tx_dma_right,
  input wire logic tx_dma_push,
  input wire logic rx_fifo_flush,
  input wire logic tx_fifo_flush
);
  wire wa = psel && penable && pwrite;
  wire ra = psel && penable && !pwrite && paddr == `OFS_RX_DMA;
  wire w1 = wa && pwdata[0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  rx_flush_a: assert property (
    w1 && paddr == `OFS_RX_FLUSH |=> rx_fifo_flush ##1 !rx_fifo_flush)
    else $error("rx flush pulse wrong");
  tx_flush_a: assert property (
    w1 && paddr == `OFS_TX_FLUSH |=> tx_fifo_flush ##1 !tx_fifo_flush)
    else $error("tx flush pulse wrong");
  rx_pop_a: assert property (ra |=> rx_dma_pop)
    else $error("rx pop missing");
  pop_cause_a: assert property (rx_dma_pop |-> $past(ra))
    else $error("rx pop without read");
  rx_side_a: assert property (ra && !rx_dma_right |=> rx_dma_right)
    else $error("rx side did not advance");
  tx_push_a: assert property (
    wa && paddr == `OFS_TX_DMA |=> tx_dma_push)
    else $error("tx push missing");
  rx_rewind_a: assert property (
    w1 && paddr == `OFS_RX_DMA_RST |=> !rx_dma_right)
    else $error("rx pointer not rewound");
  tx_rewind_a: assert property (
    w1 && paddr == `OFS_TX_DMA_RST |=> !tx_dma_right)
    else $error("tx pointer not rewound");
  cover property (rx_dma_pop);
  cover property (tx_dma_push);
  cover property (rx_fifo_flush);
endmodule // i2s_ctrl_checker
bind i2s_fifo_dma_control i2s_ctrl_checker i_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .rx_dma_right(rx_dma_right),
  .rx_dma_pop(rx_dma_pop), .tx_dma_right(tx_dma_right),
  .tx_dma_push(tx_dma_push), .rx_fifo_flush(rx_fifo_flush),
  .tx_fifo_flush(tx_fifo_flush));
`default_nettype wire

/* File: tb/test_i2s_fifo_dma_control.sv */
// Self-checking APB bench for the FIFO/DMA control block.
// Assumes the far-side model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "i2s_ctrl_defs.vh"
module test_i2s_fifo_dma_control;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [4:0] rl = 0, tl = 5'h10;
  logic ro = 0, to = 0, err;
  logic [3:0] re = 0, te = 0;
  wire [31:0] prdata, rdat, twd;
  wire pready, pslverr, irq, rr, pop, tr, push, rfl, tfl;
  wire [1:0] rch, tch;
  int miscompares = 0, comparisons = 0, i;
  i2s_fifo_dma_control i_i2s_fifo_dma_control (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_fifo_level(rl), .tx_fifo_level(tl),
    .rx_overrun_evt(ro), .tx_overrun_evt(to), .rx_ch_enable(re),
    .tx_ch_enable(te), .rx_dma_rdata(rdat), .rx_dma_ch(rch),
    .rx_dma_right(rr), .rx_dma_pop(pop), .tx_dma_ch(tch),
    .tx_dma_right(tr), .tx_dma_push(push), .tx_dma_wdata(twd),
    .rx_fifo_flush(rfl), .tx_fifo_flush(tfl), .irq(irq));
  fifo_side_model i_fifo_side_model (.rx_dma_ch(rch),
    .rx_dma_right(rr), .rx_dma_rdata(rdat));
  task automatic final_report;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, e, input string n);
    comparisons++;
    if (s !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(rd, e, "read data");
  endtask
  // Holds levels, pulses an overrun for one cycle, lets status settle
  task automatic drv(input logic o, p, input logic [4:0] r, t);
    @(posedge pclk);
    ro <= o;
    to <= p;
    rl <= r;
    tl <= t;
    @(posedge pclk);
    ro <= 0;
    to <= 0;
  endtask
  initial forever #25 pclk = ~pclk;
  initial
  begin
    #100000;
    miscompares++;
    final_report;
  end
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    rdc(`OFS_INT_MASK, 32'h33);
    rdc(`OFS_RX_TRIG, 32'h3);
    rdc(`OFS_TX_TRIG, 32'h3);
    rdc(`OFS_PARAM_RX, 32'h0);
    apb(1, `OFS_PARAM_TX, 32'hFFFFFFFF);
    rdc(`OFS_PARAM_TX, 32'h0);
    rdc(`OFS_RX_FLUSH, 32'h0);
    rdc(12'h100, 32'h0);
    chk(err, 1, "slave error");
    drv(1, 0, 0, 5'h10);
    rdc(`OFS_INT_STATUS, 32'h2);
    chk(irq, 0, "irq masked");
    apb(1, `OFS_INT_MASK, 32'h31);
    #1 chk(irq, 1, "irq unmasked");
    rdc(`OFS_RX_OVR, 32'h1);
    #1 chk(irq, 0, "irq after clear");
    rdc(`OFS_RX_OVR, 32'h0);
    drv(0, 1, 0, 5'h10);
    rdc(`OFS_INT_STATUS, 32'h20);
    rdc(`OFS_TX_OVR, 32'h1);
    rdc(`OFS_TX_OVR, 32'h0);
    apb(1, `OFS_RX_TRIG, 32'h5);
    apb(1, `OFS_TX_TRIG, 32'h2);
    drv(0, 0, 5'h4, 5'h3);
    rdc(`OFS_INT_STATUS, 32'h0);
    drv(0, 0, 5'h5, 5'h2);
    rdc(`OFS_INT_STATUS, 32'h11);
    apb(1, `OFS_INT_MASK, 32'h32);
    #1 chk(irq, 1, "irq rx avail");
    drv(0, 0, 0, 5'h10);
    apb(1, `OFS_INT_STATUS, 32'h11);
    rdc(`OFS_INT_STATUS, 32'h0);
    // Channels stay disabled while flushing
    apb(1, `OFS_RX_FLUSH, 32'h1);
    #1 chk(rfl, 1, "rx flush");
    apb(1, `OFS_TX_FLUSH, 32'h1);
    #1 chk(tfl, 1, "tx flush");
    apb(1, `OFS_RX_FLUSH, 32'h0);
    #1 chk(rfl, 0, "rx no flush");
    @(posedge pclk);
    re <= 4'h5;
    te <= 4'hA;
    apb(1, `OFS_RX_DMA_RST, 32'h1);
    apb(1, `OFS_TX_DMA_RST, 32'h1);
    for (i = 0; i < 5; i++)
    begin
      rdc(`OFS_RX_DMA, {28'hA0D0000, 1'b0, i[1], 1'b0, i[0]});
      chk(32'({tch, tr}), 32'({i[1], 1'b1, i[0]}), "tx ptr");
      apb(1, `OFS_TX_DMA, 32'hC0DE0000 + i);
      #1 chk(twd, 32'hC0DE0000 + i, "tx data");
    end
    @(posedge pclk);
    re <= 4'h6;
    apb(1, `OFS_RX_DMA_RST, 32'h1);
    rdc(`OFS_RX_DMA, 32'hA0D00002);
    apb(1, `OFS_TX_DMA_RST, 32'h1);
    #1 chk(32'({tch, tr}), 32'h2, "tx rewind");
    final_report;
  end
endmodule // test_i2s_fifo_dma_control
`default_nettype wire
